// File: include/serial_command_port_pkg.sv
// Constants, field layouts and carrier types for the serial command port.
// Assumes one system clock; the serial pins arrive asynchronously to it.
//
// Notes on behaviour
// - A frame is 24 bits, MSB first, one bit per rising serial clock.
// - Upper 8 bits are the address byte, lower 16 bits the data word.
// - Bits shift regardless of latch; frame captured on every latch rise.
// - Shift register clears to zero at power-on and after any reset.
// - Addresses 01,55,56,57,58,59 write data, control, reset, setup, gain, offset.
// - Address 00 is no-operation, 95 restarts the watchdog; neither stores.
// - Read request uses address 02, select code in data bits 5..0.
// - Frame after a read shifts out the selected register MSB first, falling edges.
// - Select codes pick status, data, control, setup, gain or offset.
// - Registers change only at latch rise; burst or continuous clock accepted.
// - With chain enable set, shifted data leaves on the serial output.
// - Chained write takes one frame, readback two.
// - All chained devices update together on the latch rise.
// - Narrow variant keeps data in bits 15..4; bits 3..0 read as zero.

`default_nettype none

package serial_command_port_pkg;

   localparam int FRAME_BITS = 24;
   localparam int ADDR_BITS  = 8;
   localparam int WORD_BITS  = 16;
   localparam int SEL_BITS   = 6;

   // ****************************************
   // Address byte codes
   // ****************************************
   localparam logic [7:0] ADDR_NOP         = 8'h00;
   localparam logic [7:0] ADDR_OUTPUT_CODE = 8'h01;
   localparam logic [7:0] ADDR_READ        = 8'h02;
   localparam logic [7:0] ADDR_CONTROL     = 8'h55;
   localparam logic [7:0] ADDR_SOFT_RESET  = 8'h56;
   localparam logic [7:0] ADDR_SETUP       = 8'h57;
   localparam logic [7:0] ADDR_GAIN_TRIM   = 8'h58;
   localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h59;
   localparam logic [7:0] ADDR_WD_RESTART  = 8'h95;

   // ****************************************
   // Read select codes (low bits where don't care applies)
   // ****************************************
   localparam logic [1:0] SEL_STATUS      = 2'h0;
   localparam logic [1:0] SEL_OUTPUT_CODE = 2'h1;
   localparam logic [1:0] SEL_CONTROL     = 2'h2;
   localparam logic [5:0] SEL_SETUP       = 6'h0B;
   localparam logic [5:0] SEL_GAIN_TRIM   = 6'h13;
   localparam logic [5:0] SEL_OFFSET_TRIM = 6'h17;

   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int          CHAIN_ENABLE_POS   = 3;
   localparam int          SOFT_RESET_POS     = 0;
   localparam int          NARROW_LOW_BITS    = 4;
   localparam logic [23:0] FRAME_RESET        = 24'h000000;
   localparam logic [15:0] WORD_RESET         = 16'h0000;
   localparam logic [15:0] GAIN_TRIM_RESET    = 16'h0000;
   localparam int          SYNC_STAGES        = 3;

   // Frame carrier
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] data;
   } frame_type;

   // Pin sample carrier
   typedef struct packed {
      logic sclk;
      logic sdi;
      logic latch;
   } pins_type;

endpackage : serial_command_port_pkg

`default_nettype wire

// File: rtl/serial_command_port.sv
// Serial command port: shift register, latch decode, register file, readback.
// Assumes clk much faster than the host serial clock (about 8x or more);
// all pins are sampled and edges are found on clk.
// Fault levels pass the same filter; registers and sdo reset to zero.

`timescale 1ns/100ps
`default_nettype none

module serial_command_port
   import serial_command_port_pkg::*;
#(
   parameter bit NARROW_DATA = 1'b0
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        sclk,
   input  wire logic        sdi,
   input  wire logic        latch,
   input  wire logic [4:0]  fault_in,
   output var  logic        sdo,
   output var  logic [15:0] output_code,
   output var  logic [15:0] main_control,
   output var  logic [15:0] setup,
   output var  logic [15:0] gain_trim,
   output var  logic [15:0] offset_trim,
   output var  logic        watchdog_restart,
   output var  logic        soft_reset_pulse
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   pins_type s1_reg;
   pins_type s2_reg;
   pins_type s3_reg;
   pins_type stable_reg;
   pins_type pins_now;
   logic [4:0] flt1_reg;
   logic [4:0] flt2_reg;
   logic [4:0] flt3_reg;
   logic [4:0] fault_sync_reg;

   assign pins_now = '{sclk: sclk, sdi: sdi, latch: latch};

   // Three stages; a level counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_reg     <= '0;
         s2_reg     <= '0;
         s3_reg     <= '0;
         stable_reg <= '0;
      end else begin
         s1_reg <= pins_now;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg.sclk == s3_reg.sclk) stable_reg.sclk <= s3_reg.sclk;
         if (s2_reg.sdi == s3_reg.sdi) stable_reg.sdi <= s3_reg.sdi;
         if (s2_reg.latch == s3_reg.latch) stable_reg.latch <= s3_reg.latch;
      end
   end

   // Fault levels take the same three stages as the serial pins
   always_ff @(posedge clk) begin
      if (srst) begin
         flt1_reg <= '0;
         flt2_reg <= '0;
         flt3_reg <= '0;
      end else begin
         flt1_reg <= fault_in;
         flt2_reg <= flt1_reg;
         flt3_reg <= flt2_reg;
      end
   end

   // ****************************************
   // Fault filter
   // ****************************************
   // Per bit: a level counts once stages two and three agree,
   // so one late sample near a transition never reaches status
   for (genvar b = 0; b < 5; b++) begin : g_fault_filter
      always_ff @(posedge clk) begin
         if (srst) begin
            fault_sync_reg[b] <= 1'b0;
         end else if (flt2_reg[b] == flt3_reg[b]) begin
            fault_sync_reg[b] <= flt3_reg[b];
         end
      end
   end

   // ****************************************
   // Edge detection
   // ****************************************
   logic sclk_rise;
   logic sclk_fall;
   logic latch_rise;
   logic agree_sclk;
   logic agree_latch;

   // Edge when the filtered level is about to change
   assign agree_sclk  = (s2_reg.sclk == s3_reg.sclk);
   assign agree_latch = (s2_reg.latch == s3_reg.latch);
   assign sclk_rise   = agree_sclk & s3_reg.sclk & ~stable_reg.sclk;
   assign sclk_fall   = agree_sclk & ~s3_reg.sclk & stable_reg.sclk;
   assign latch_rise  = agree_latch & s3_reg.latch & ~stable_reg.latch;

   // ****************************************
   // Frame path declarations
   // ****************************************
   // Declared ahead of the shift register, which reloads from the read path
   logic [15:0] wdata;
   logic        load_pending;
   logic [15:0] read_word;
   logic [5:0]  sel;
   logic        chain_enable;
   logic        readback_armed;
   logic [4:0]  wr_en;

   // ****************************************
   // Shift register
   // ****************************************
   logic [23:0] shift_reg;
   logic        soft_rst;

   // Shifts whatever the latch level; cleared by any reset
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         shift_reg <= FRAME_RESET;
      end else if (latch_rise && load_pending) begin
         shift_reg <= {read_word, 8'h00};
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[22:0], stable_reg.sdi};
      end
   end

   frame_type frame;
   assign frame = frame_type'(shift_reg);

   // ****************************************
   // Latch decode and register file
   // ****************************************
   // Narrow variant drops the low data bits on output code writes
   assign wdata = NARROW_DATA ? {frame.data[15:4], 4'h0} : frame.data;
   assign sel   = frame.data[5:0];
   assign load_pending = (frame.addr == ADDR_READ);

   // One write strobe per register, live only in the latch-rise cycle;
   // an address that decodes to nothing leaves every strobe low
   always_comb begin
      wr_en = 5'h00;
      if (!latch_rise) begin
         wr_en = 5'h00;
      end else if (frame.addr == ADDR_OUTPUT_CODE) begin
         wr_en[0] = 1'b1;
      end else if (frame.addr == ADDR_CONTROL) begin
         wr_en[1] = 1'b1;
      end else if (frame.addr == ADDR_SETUP) begin
         wr_en[2] = 1'b1;
      end else if (frame.addr == ADDR_GAIN_TRIM) begin
         wr_en[3] = 1'b1;
      end else if (frame.addr == ADDR_OFFSET_TRIM) begin
         wr_en[4] = 1'b1;
      end else begin
         wr_en = 5'h00;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   // Output code; chained devices all store on the same latch rise
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         output_code <= WORD_RESET;
      end else if (wr_en[0]) begin
         output_code <= wdata;
      end
   end

   // Main control; bit 3 steers the serial output
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         main_control <= WORD_RESET;
      end else if (wr_en[1]) begin
         main_control <= frame.data;
      end
   end

   // Setup word, stored as written
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         setup <= WORD_RESET;
      end else if (wr_en[2]) begin
         setup <= frame.data;
      end
   end

   // Gain trim has its own reset constant
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         gain_trim <= GAIN_TRIM_RESET;
      end else if (wr_en[3]) begin
         gain_trim <= frame.data;
      end
   end

   // Offset trim, stored as written
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         offset_trim <= WORD_RESET;
      end else if (wr_en[4]) begin
         offset_trim <= frame.data;
      end
   end

   // ****************************************
   // Command pulses
   // ****************************************
   // Command pulses; soft reset clears state on the next cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         watchdog_restart <= 1'b0;
         soft_reset_pulse <= 1'b0;
         soft_rst         <= 1'b0;
      end else begin
         watchdog_restart <= latch_rise && (frame.addr == ADDR_WD_RESTART);
         soft_rst <= latch_rise && (frame.addr == ADDR_SOFT_RESET)
                     && frame.data[SOFT_RESET_POS];
         soft_reset_pulse <= soft_rst;
      end
   end

   // ****************************************
   // Readback selection
   // ****************************************
   logic [15:0] status_word;
   assign status_word = {11'h000, fault_sync_reg};

   // Explicit codes first, then the don't-care low-bit codes
   always_comb begin
      if (sel == SEL_SETUP) begin
         read_word = setup;
      end else if (sel == SEL_GAIN_TRIM) begin
         read_word = gain_trim;
      end else if (sel == SEL_OFFSET_TRIM) begin
         read_word = offset_trim;
      end else if (sel[1:0] == SEL_STATUS) begin
         read_word = status_word;
      end else if (sel[1:0] == SEL_OUTPUT_CODE) begin
         read_word = output_code;
      end else if (sel[1:0] == SEL_CONTROL) begin
         read_word = main_control;
      end else begin
         read_word = WORD_RESET;
      end
   end

   // ****************************************
   // Serial output
   // ****************************************
   // Chain enable is the stored control bit; it gates what leaves on sdo
   assign chain_enable = main_control[CHAIN_ENABLE_POS];

   // Armed by a read latch, disarmed by the next latch: the frame in
   // between is the one that carries the selected register out
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         readback_armed <= 1'b0;
      end else if (latch_rise) begin
         readback_armed <= load_pending;
      end
   end

   // Bit 23 goes out at the latch rise already, so the host or the next
   // device takes the MSB on the first rising edge of the next frame;
   // later bits follow each falling edge. Stand-alone with no read armed
   // keeps sdo low, so a stray frame never shows old shift contents.
   always_ff @(posedge clk) begin
      if (srst || soft_rst) begin
         sdo <= 1'b0;
      end else if (latch_rise) begin
         if (load_pending) begin
            sdo <= read_word[15];
         end else if (chain_enable) begin
            sdo <= shift_reg[23];
         end else begin
            sdo <= 1'b0;
         end
      end else if (sclk_fall) begin
         if (chain_enable || readback_armed) begin
            sdo <= shift_reg[23];
         end else begin
            sdo <= 1'b0;
         end
      end
   end

endmodule : serial_command_port

`default_nettype wire

// File: testbench/scp_checker_assertions.sv
// Concurrent checks on the serial command port pins and registers.
// Assumes one clk domain; bound to every design instance below.
`timescale 1ns/100ps
`default_nettype none
module scp_checker #(parameter bit NARROW_DATA = 1'b0) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        sclk,
   input wire logic        latch,
   input wire logic        sdo,
   input wire logic [15:0] output_code,
   input wire logic [15:0] main_control,
   input wire logic [15:0] setup,
   input wire logic [15:0] gain_trim,
   input wire logic [15:0] offset_trim,
   input wire logic        watchdog_restart,
   input wire logic        soft_reset_pulse
);
   logic [79:0] regs;
   logic [3:0]  lw;
   logic [3:0]  fw;
   assign regs = {output_code, main_control, setup, gain_trim, offset_trim};
   // Windows after raw pin edges; pins pass synchronisers, so the design acts late
   always_ff @(posedge clk) begin
      if (srst) begin
         lw <= 4'h0;
         fw <= 4'h0;
      end else begin
         lw <= $rose(latch) ? 4'hC : lw - {3'h0, lw != 4'h0};
         fw <= $fell(sclk) ? 4'hC : fw - {3'h0, fw != 4'h0};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_reset_clears: assert property (disable iff (1'b0) srst |=> regs == 80'h0 && !sdo)
      else $error("reset left state");
   a_update_latch: assert property ($changed(regs) |-> lw != 4'h0)
      else $error("register changed without latch");
   a_sdo_hold: assert property ($changed(sdo) |-> fw != 4'h0 || lw != 4'h0)
      else $error("sdo moved off its edges");
   a_narrow_low: assert property (NARROW_DATA |-> output_code[3:0] == 4'h0)
      else $error("narrow low bits set");
   a_wd_pulse: assert property (watchdog_restart |=> !watchdog_restart)
      else $error("restart pulse too long");
   a_wd_cause: assert property (watchdog_restart |-> lw != 4'h0 && $stable(regs))
      else $error("restart without latch or with store");
   a_soft_clear: assert property (soft_reset_pulse |-> regs == 80'h0 && !sdo)
      else $error("soft reset left state");
   a_soft_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse too long");
   c_restart: cover property (watchdog_restart);
   c_soft: cover property (soft_reset_pulse);
   c_chain: cover property ($rose(main_control[3]));
endmodule : scp_checker
bind serial_command_port scp_checker #(.NARROW_DATA(NARROW_DATA)) i_scp_checker (
   .clk(clk), .srst(srst), .sclk(sclk), .latch(latch), .sdo(sdo),
   .output_code(output_code), .main_control(main_control), .setup(setup),
   .gain_trim(gain_trim), .offset_trim(offset_trim),
   .watchdog_restart(watchdog_restart), .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

// File: testbench/serial_host.sv
// Host serial master model: drives clock, data and latch, samples sdo.
// Assumes clk at 250 MHz; one serial clock lasts 31 or 32 clk cycles.
`timescale 1ns/100ps
`default_nettype none
module serial_host (
   input  wire logic        clk,
   input  wire logic        sdo,
   output var  logic        sclk,
   output var  logic        sdi,
   output var  logic        latch,
   output var  logic        rd_done,
   output var  logic [23:0] rd
);
   // Idle levels; sclk stands low between frames
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      latch = 1'b0;
      rd_done = 1'b0;
      rd = 24'h000000;
   end
   // Low n bits of w, MSB first, then latch after exactly n clocks
   task send(input logic [47:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= w[i];
         // One low phase in four is a clk longer: the period averages 125 ns
         repeat ((i % 4 == 0) ? 16 : 15) @(posedge clk);
         rd <= {rd[22:0], sdo};
         sclk <= 1'b1;
         repeat (16) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      latch <= 1'b1;
      sdi <= ~sdi;
      repeat (16) @(posedge clk);
      latch <= 1'b0;
      rd_done <= 1'b1;
      @(posedge clk);
      rd_done <= 1'b0;
      @(posedge clk);
   endtask : send
endmodule : serial_host
`default_nettype wire

// File: testbench/serial_command_port_tb.sv
// Testbench: host model sends frames, a watcher compares readback words.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module serial_command_port_tb;
   import serial_command_port_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [4:0]  fault_in = 5'h00;
   logic        sclk, sdi, latch, sdo, rd_done;
   logic [23:0] rd;
   logic [23:0] q [$];
   logic [15:0] val [6] = '{default: 16'h0000};
   logic [7:0]  wa [6] = '{8'h00, 8'h01, 8'h55, 8'h57, 8'h58, 8'h59};
   logic [5:0]  sel [6] = '{6'h00, 6'h01, 6'h02, 6'h0B, 6'h13, 6'h17};
   logic [7:0]  cmd [5] = '{8'h00, 8'h95, 8'h03, 8'h5A, 8'hFF};
   int          error_cnt = 0;
   int          n_compared = 0;
   int          wd_cnt = 0;
   int          sr_cnt = 0;
   logic        wd_pulse, sr_pulse;
   initial forever #2 clk = ~clk;
   serial_command_port #(.NARROW_DATA(1'b1)) i_serial_command_port (.clk(clk), .srst(srst),
      .sclk(sclk), .sdi(sdi), .latch(latch), .fault_in(fault_in), .sdo(sdo), .output_code(),
      .main_control(), .setup(), .gain_trim(), .offset_trim(), .watchdog_restart(wd_pulse),
      .soft_reset_pulse(sr_pulse));
   serial_host i_serial_host (.clk(clk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .latch(latch),
      .rd_done(rd_done), .rd(rd));
   task check(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // Watcher: a finished frame with a note pending is compared
   always @(posedge clk) if (rd_done && q.size() > 0) check(rd, q.pop_front());
   // Pulse counters for the command outputs
   always @(posedge clk) begin
      if (wd_pulse === 1'b1) wd_cnt++;
      if (sr_pulse === 1'b1) sr_cnt++;
   end
   // Read all six; low-two-bit codes get random don't-care bits
   task rdall;
      for (int i = 0; i < 6; i++) begin
         i_serial_host.send({24'h0, 8'h02, 10'($urandom),
            i < 3 ? {4'($urandom), sel[i][1:0]} : sel[i]}, 24);
         q.push_back({val[i], 8'h00});
         i_serial_host.send(48'h0, 24);
      end
   endtask : rdall
   task wr(input int i, input logic [15:0] d);
      i_serial_host.send({24'h0, wa[i], d}, 24);
      val[i] = i == 1 ? d & 16'hFFF0 : d;
   endtask : wr
   initial begin : main
      logic [23:0] a;
      void'($urandom(80));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      rdall();
      val[0][4:0] = 5'($urandom);
      fault_in <= val[0][4:0];
      for (int i = 1; i < 6; i++) wr(i, 16'($urandom));
      rdall();
      // Commands and unknown addresses must store nothing
      foreach (cmd[k]) i_serial_host.send({24'h0, cmd[k], 16'($urandom)}, 24);
      check(24'(wd_cnt), 24'h000001);
      rdall();
      // Chained frame: first word passes out on sdo, last word lands here
      wr(2, 16'h0008);
      a = 24'($urandom);
      q.push_back(a);
      val[2] = 16'($urandom);
      i_serial_host.send({a, 8'h55, val[2]}, 48);
      rdall();
      i_serial_host.send({24'h0, 8'h56, 16'h0001}, 24);
      for (int i = 1; i < 6; i++) val[i] = 16'h0000;
      check(24'(sr_cnt), 24'h000001);
      rdall();
      complete_run();
   end
   // Hang guard
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      complete_run();
   end
endmodule : serial_command_port_tb
`default_nettype wire
